// [tb_top.sv]
// Self-checking bench of the write guard, unlock window, failure level and alarms.
// Assumes the tool model as bus master and a short unlock window parameter.
`timescale 1ns/1ps
module tb_top;
  import wpa_pkg::*;
  localparam longint UNL = 50;
  logic clock, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [7:0] wb_adr_i, alarm_code;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic fail_direction_switch, write_inhibit_switch, cpu_fail, fail_active;
  logic signed [15:0] pv_dp, pv_static, pv_ext_temp, pv_flow;
  logic signed [WPA_LVL_W-1:0] loop_level;
  int n_mismatch, checked;

  // ==========================================================
  // Design and tool model.
  wpa_top #(.UNLOCK_CYCLES(UNL)) u_wpa_top (.clock(clock), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq(irq), .fail_direction_switch(fail_direction_switch),
    .write_inhibit_switch(write_inhibit_switch), .cpu_fail(cpu_fail), .pv_dp(pv_dp),
    .pv_static(pv_static), .pv_ext_temp(pv_ext_temp), .pv_flow(pv_flow),
    .loop_level(loop_level), .fail_active(fail_active), .alarm_code(alarm_code));
  wpa_tool_model u_wpa_tool_model (.clock(clock), .wb_cyc(wb_cyc_i), .wb_stb(wb_stb_i),
    .wb_we(wb_we_i), .wb_adr(wb_adr_i), .wb_sel(wb_sel_i), .wb_dat_w(wb_dat_i),
    .wb_dat_r(wb_dat_o), .wb_ack(wb_ack_o));

  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================================
  // Shared helpers.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    logic ok;
    u_wpa_tool_model.xfer(1'b1, adr, dat, d, ok);
    chk({31'h0, ok}, 32'h1);
    // A bus that never answers ends the run at once.
    if (!ok) begin
      close_out();
    end
  endtask

  task automatic rd(input logic [7:0] adr, output logic [31:0] d);
    logic ok;
    u_wpa_tool_model.xfer(1'b0, adr, 32'h0, d, ok);
    chk({31'h0, ok}, 32'h1);
    // A bus that never answers ends the run at once.
    if (!ok) begin
      close_out();
    end
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios.
  // Status after reset and the direction switch as seen by software.
  task automatic t_state();
    logic [31:0] d;
    rd(WPA_A_STATE, d);
    chk(d & 32'h2f, 32'h28);
    @(posedge clock);
    fail_direction_switch <= 1'b0;
    rd(WPA_A_STATE, d);
    chk(d & 32'h2f, 32'h00);
  endtask

  // Hardware inhibit refuses writes, flags an event and raises the masked interrupt.
  task automatic t_inhibit();
    logic [31:0] d;
    wr(WPA_A_MASK, 32'h100);
    @(posedge clock);
    write_inhibit_switch <= 1'b1;
    wr(WPA_A_MODE, 32'hff);
    rd(WPA_A_MODE, d);
    chk(d, 32'h0);
    rd(WPA_A_EVT, d);
    chk(d & 32'h104, 32'h100);
    chk({31'h0, irq}, 32'h1);
    wr(WPA_A_EVT, 32'h100);
    repeat (3) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    write_inhibit_switch <= 1'b0;
    wr(WPA_A_MODE, 32'hff);
    rd(WPA_A_MODE, d);
    chk(d, 32'hff);
    wr(WPA_A_MODE, 32'h0);
  endtask

  // Password, refusal, wrong and right unlock, expiry, and release by spaces.
  task automatic t_password();
    logic [31:0] d;
    wr(WPA_A_NPW_LO, 32'h44434241);
    wr(WPA_A_NPW_HI, 32'h48474645);
    rd(WPA_A_STATE, d);
    chk(d & 32'h3, 32'h1);
    wr(WPA_A_MODE, 32'h55);
    rd(WPA_A_MODE, d);
    chk(d, 32'h0);
    wr(WPA_A_THR0, 32'h7);
    rd(WPA_A_THR0, d);
    chk(d, 32'h0);
    wr(WPA_A_UNL_LO, 32'h44434241);
    wr(WPA_A_UNL_HI, 32'h48474646);
    rd(WPA_A_STATE, d);
    chk(d & 32'h3, 32'h1);
    wr(WPA_A_UNL_LO, 32'h44434241);
    wr(WPA_A_UNL_HI, 32'h48474645);
    rd(WPA_A_STATE, d);
    chk(d & 32'h3, 32'h3);
    wr(WPA_A_MODE, 32'h55);
    rd(WPA_A_MODE, d);
    chk(d, 32'h55);
    repeat (UNL + 5) @(posedge clock);
    rd(WPA_A_STATE, d);
    chk(d & 32'h3, 32'h1);
    rd(WPA_A_EVT, d);
    chk(d & 32'h200, 32'h200);
    wr(WPA_A_MODE, 32'h0);
    rd(WPA_A_MODE, d);
    chk(d, 32'h55);
    wr(WPA_A_UNL_LO, 32'h44434241);
    wr(WPA_A_UNL_HI, 32'h48474645);
    wr(WPA_A_NPW_LO, 32'h20202020);
    wr(WPA_A_NPW_HI, 32'h20202020);
    rd(WPA_A_STATE, d);
    chk(d & 32'h3, 32'h0);
    wr(WPA_A_MODE, 32'h0);
    rd(WPA_A_MODE, d);
    chk(d, 32'h0);
  endtask

  // Every alert mode against distinct per-variable thresholds, both directions.
  task automatic t_alarm();
    logic [31:0] d;
    logic [7:0] e;
    logic [1:0] m;
    int i, k, p;
    for (i = 0; i < 4; i++) begin
      wr(WPA_A_THR0 + 8'(8 * i), 32'(10 * (i + 1)));
      wr(WPA_A_THR0 + 8'(8 * i + 4), 32'(-10 * (i + 1)));
    end
    for (k = 0; k < 4; k++) begin
      m = 2'(k);
      wr(WPA_A_MODE, {24'h0, {4{m}}});
      for (p = -25; p <= 25; p += 50) begin
        @(posedge clock);
        {pv_dp, pv_static, pv_ext_temp, pv_flow} <= {4{16'(p)}};
        repeat (4) @(posedge clock);
        e = 8'h00;
        for (i = 0; i < 4; i++) begin
          e[2 * i] = m[0] && (p > 10 * (i + 1));
          e[2 * i + 1] = m[1] && (p < -10 * (i + 1));
        end
        chk({24'h0, alarm_code}, {24'h0, e});
        rd(WPA_A_ALARM, d);
        chk(d, {24'h0, e});
      end
    end
    {pv_dp, pv_static, pv_ext_temp, pv_flow} <= 64'h0;
    wr(WPA_A_MODE, 32'h0);
  endtask

  // Processor failure drives the selected level and silences the bus until reset.
  task automatic t_fail(input logic dir, input logic signed [WPA_LVL_W-1:0] lvl);
    logic [31:0] d;
    logic ok;
    @(posedge clock);
    fail_direction_switch <= dir;
    rd(WPA_A_STATE, d);
    chk((d >> 5) & 32'h1, {31'h0, dir});
    cpu_fail <= 1'b1;
    repeat (4) @(posedge clock);
    chk({20'h0, loop_level}, {20'h0, lvl});
    chk({31'h0, fail_active}, 32'h1);
    u_wpa_tool_model.xfer(1'b0, WPA_A_STATE, 32'h0, d, ok);
    chk({31'h0, ok}, 32'h0);
    rst_b <= 1'b0;
    cpu_fail <= 1'b0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    n_mismatch = 0;
    checked = 0;
    rst_b = 1'b0;
    fail_direction_switch = 1'b1;
    write_inhibit_switch = 1'b0;
    cpu_fail = 1'b0;
    {pv_dp, pv_static, pv_ext_temp, pv_flow} = 64'h0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    t_state();
    t_inhibit();
    t_password();
    t_alarm();
    t_fail(1'b1, WPA_LVL_HIGH);
    t_fail(1'b0, WPA_LVL_LOW);
    close_out();
  end
endmodule

// [wpa_pkg.sv]
// Constants, register map and carrier types of the write-guard and alarm block.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone register bus.
package wpa_pkg;

  // ==========================================================
  // Timing
  localparam longint WPA_CLK_HZ = 100_000_000;
  localparam longint WPA_UNLOCK_MIN = 10;
  localparam longint WPA_UNLOCK_CYC = WPA_UNLOCK_MIN * 60 * WPA_CLK_HZ;

  // ==========================================================
  // Failure output levels in tenths of a percent of span.
  localparam int WPA_LVL_W = 12;
  localparam logic signed [WPA_LVL_W-1:0] WPA_LVL_HIGH = 12'sd1100;
  localparam logic signed [WPA_LVL_W-1:0] WPA_LVL_LOW = -12'sd25;
  localparam logic signed [WPA_LVL_W-1:0] WPA_LVL_NONE = 12'sd0;

  // ==========================================================
  // Register byte addresses.
  localparam logic [7:0] WPA_A_STATE = 8'h00;
  localparam logic [7:0] WPA_A_NPW_LO = 8'h04;
  localparam logic [7:0] WPA_A_NPW_HI = 8'h08;
  localparam logic [7:0] WPA_A_UNL_LO = 8'h0c;
  localparam logic [7:0] WPA_A_UNL_HI = 8'h10;
  localparam logic [7:0] WPA_A_MODE = 8'h14;
  localparam logic [7:0] WPA_A_THR0 = 8'h18;
  localparam logic [7:0] WPA_A_THR_END = 8'h38;
  localparam logic [7:0] WPA_A_EVT = 8'h38;
  localparam logic [7:0] WPA_A_MASK = 8'h3c;
  localparam logic [7:0] WPA_A_ALARM = 8'h40;

  // ==========================================================
  // State register bits.
  localparam int WPA_S_PROT = 0;
  localparam int WPA_S_UNL = 1;
  localparam int WPA_S_HWI = 2;
  localparam int WPA_S_DIR = 3;
  localparam int WPA_S_FAIL = 4;
  localparam int WPA_S_LVL = 5;

  // Event status bits: alarms 0..7, then these.
  localparam int WPA_NVAR = 4;
  localparam int WPA_E_REJ = 8;
  localparam int WPA_E_EXP = 9;
  localparam int WPA_EVT_W = 10;

  // ==========================================================
  // Password constants.
  localparam logic [63:0] WPA_PW_SPACES = 64'h2020202020202020;

  // Alert modes of one monitored variable.
  typedef enum logic [1:0] {
    WPA_ALERT_OFF = 2'h0,
    WPA_ALERT_UPPER = 2'h1,
    WPA_ALERT_LOWER = 2'h2,
    WPA_ALERT_BOTH = 2'h3
  } wpa_alert_t;

  // Threshold pair of one monitored variable.
  typedef struct packed {
    logic signed [15:0] upper;
    logic signed [15:0] lower;
  } wpa_thr_t;

endpackage

// [wpa_tool_model.sv]
// Behavioural configuration tool that writes and reads parameters over classic Wishbone.
// Assumes one rising-edge clock shared with the block; the bench calls xfer hierarchically.
`timescale 1ns/1ps
module wpa_tool_model (
  input wire logic clock,
  output logic wb_cyc,
  output logic wb_stb,
  output logic wb_we,
  output logic [7:0] wb_adr,
  output logic [3:0] wb_sel,
  output logic [31:0] wb_dat_w,
  input wire logic [31:0] wb_dat_r,
  input wire logic wb_ack
);
  // ==========================================================
  // Idle bus at time zero.
  initial begin
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'hf;
    wb_dat_w = 32'h00000000;
  end

  // One single cycle; ok stays low if no answer comes within the bound.
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                      output logic [31:0] rdat, output logic ok);
    int n;
    ok = 1'b0;
    rdat = 32'h00000000;
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= wdat;
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge clock);
      if (wb_ack === 1'b1) begin
        ok = 1'b1;
        rdat = wb_dat_r;
      end
    end
    // Released data shows the inverse so stale values are never mistaken for live ones.
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    wb_dat_w <= ~wdat;
  endtask
endmodule

// [wpa_top.sv]
// Write guard, password unlock window, failure level and process alarms.
// Assumes switches, failure flag and process values synchronous to clock.
//
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
module wpa_top
  import wpa_pkg::*;
#(
  parameter longint UNLOCK_CYCLES = WPA_UNLOCK_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic fail_direction_switch,
  input wire logic write_inhibit_switch,
  input wire logic cpu_fail,
  input wire logic signed [15:0] pv_dp,
  input wire logic signed [15:0] pv_static,
  input wire logic signed [15:0] pv_ext_temp,
  input wire logic signed [15:0] pv_flow,
  output logic signed [WPA_LVL_W-1:0] loop_level,
  output logic fail_active,
  output logic [7:0] alarm_code
);

  // ==========================================================
  // Helper functions.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic all_alnum(input logic [63:0] s);
    logic ok;
    logic [7:0] c;
    ok = 1'b1;
    for (int b = 0; b < 8; b++) begin
      c = s[b*8 +: 8];
      if (!((c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5a) ||
            (c >= 8'h61 && c <= 8'h7a))) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // ==========================================================
  // Bus handshake.
  logic fail_r;
  logic acc;
  logic wr;
  logic [31:0] rdata_nxt;
  logic [WPA_EVT_W-1:0] evt_r;
  logic [WPA_EVT_W-1:0] mask_r;
  logic [7:0] mode_r;
  wpa_thr_t thr_r [WPA_NVAR];
  logic [63:0] pw_r;
  logic [31:0] npw_lo_r;
  logic [31:0] unl_lo_r;
  logic protect_r;
  logic dir_lat_r;
  logic unl_active;
  logic unl_expired;
  logic unl_start;
  logic unl_stop;
  logic param_ok;
  logic reject_ev;
  logic [7:0] alarm_now;
  logic signed [15:0] pv [WPA_NVAR];

  assign pv[0] = pv_dp;
  assign pv[1] = pv_static;
  assign pv[2] = pv_ext_temp;
  assign pv[3] = pv_flow;

  // One-cycle ack; writes land at the edge where ack is sampled high.
  assign acc = wb_cyc_i && wb_stb_i && wb_ack_o;
  assign wr = acc && wb_we_i;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !fail_r && !cpu_fail;
    end
  end

  // ==========================================================
  // Failure latch and loop level.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fail_r <= 1'b0;
      dir_lat_r <= 1'b1;
    end else if (!fail_r) begin
      fail_r <= cpu_fail;
      dir_lat_r <= fail_direction_switch;
    end
  end

  // Drives the failure level once the processor has failed.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      loop_level <= WPA_LVL_NONE;
      fail_active <= 1'b0;
    end else begin
      fail_active <= fail_r;
      if (!fail_r) begin
        loop_level <= WPA_LVL_NONE;
      end else if (dir_lat_r) begin
        loop_level <= WPA_LVL_HIGH;
      end else begin
        loop_level <= WPA_LVL_LOW;
      end
    end
  end

  // ==========================================================
  // Write guard and passwords.
  assign param_ok = !write_inhibit_switch && (!protect_r || unl_active);

  wire npw_go = wr && wb_adr_i == WPA_A_NPW_HI;
  wire unl_go = wr && wb_adr_i == WPA_A_UNL_HI;
  wire [63:0] npw_val = {wb_dat_i, npw_lo_r};
  wire [63:0] unl_val = {wb_dat_i, unl_lo_r};
  wire npw_spaces = npw_val == WPA_PW_SPACES;
  wire npw_valid = all_alnum(npw_val);
  wire guarded_wr = wr && ((wb_adr_i >= WPA_A_MODE && wb_adr_i < WPA_A_THR_END) || npw_go);
  wire unl_match = protect_r && unl_val == pw_r;

  assign unl_start = unl_go && unl_match;
  assign unl_stop = npw_go && param_ok && npw_spaces;
  assign reject_ev = (guarded_wr && !param_ok) || (npw_go && !npw_spaces && !npw_valid) ||
                     (unl_go && !unl_match);

  // Low password halves are staged; the high half commits.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      npw_lo_r <= '0;
      unl_lo_r <= '0;
    end else begin
      if (wr && wb_adr_i == WPA_A_NPW_LO) begin
        npw_lo_r <= merge(npw_lo_r, wb_dat_i, wb_sel_i);
      end
      if (wr && wb_adr_i == WPA_A_UNL_LO) begin
        unl_lo_r <= merge(unl_lo_r, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Protection state and stored password.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      protect_r <= 1'b0;
      pw_r <= WPA_PW_SPACES;
    end else if (npw_go && param_ok) begin
      if (npw_spaces) begin
        protect_r <= 1'b0;
        pw_r <= WPA_PW_SPACES;
      end else if (npw_valid) begin
        protect_r <= 1'b1;
        pw_r <= npw_val;
      end
    end
  end

  wpa_unlock_timer #(
    .CYCLES(UNLOCK_CYCLES)
  ) u_timer (
    .clock(clock),
    .rst_b(rst_b),
    .start(unl_start),
    .stop(unl_stop),
    .active(unl_active),
    .expired(unl_expired)
  );

  // ==========================================================
  // Alert modes and thresholds.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= '0;
    end else if (wr && param_ok && wb_adr_i == WPA_A_MODE) begin
      mode_r <= wb_dat_i[7:0];
    end
  end

  for (genvar i = 0; i < WPA_NVAR; i++) begin : g_var
    localparam logic [7:0] AU = WPA_A_THR0 + 8'(i * 8);
    localparam logic [7:0] AL = AU + 8'h04;
    wpa_alert_t md;
    assign md = wpa_alert_t'(mode_r[i*2 +: 2]);

    // Threshold pair of this variable.
    always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
        thr_r[i] <= '0;
      end else if (wr && param_ok) begin
        if (wb_adr_i == AU) begin
          thr_r[i].upper <= 16'(merge(32'(thr_r[i].upper), wb_dat_i, wb_sel_i));
        end
        if (wb_adr_i == AL) begin
          thr_r[i].lower <= 16'(merge(32'(thr_r[i].lower), wb_dat_i, wb_sel_i));
        end
      end
    end

    // Comparators gated by the alert mode.
    assign alarm_now[i*2] = (md == WPA_ALERT_UPPER || md == WPA_ALERT_BOTH) &&
                            pv[i] > thr_r[i].upper;
    assign alarm_now[i*2+1] = (md == WPA_ALERT_LOWER || md == WPA_ALERT_BOTH) &&
                              pv[i] < thr_r[i].lower;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      alarm_code <= '0;
    end else begin
      alarm_code <= alarm_now;
    end
  end

  // ==========================================================
  // Events, mask and interrupt; a set beats a same-cycle clear.
  wire [WPA_EVT_W-1:0] evt_set = {unl_expired, reject_ev, alarm_now};
  wire [WPA_EVT_W-1:0] evt_clr = (wr && wb_adr_i == WPA_A_EVT) ? wb_dat_i[WPA_EVT_W-1:0] : '0;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      evt_r <= '0;
    end else begin
      evt_r <= (evt_r & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mask_r <= '0;
    end else if (wr && wb_adr_i == WPA_A_MASK) begin
      mask_r <= wb_dat_i[WPA_EVT_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_r & mask_r);
    end
  end

  // ==========================================================
  // Read data, captured with ack.
  always_comb begin
    rdata_nxt = '0;
    case (wb_adr_i)
      WPA_A_STATE: begin
        rdata_nxt[WPA_S_PROT] = protect_r;
        rdata_nxt[WPA_S_UNL] = unl_active;
        rdata_nxt[WPA_S_HWI] = write_inhibit_switch;
        rdata_nxt[WPA_S_DIR] = fail_direction_switch;
        rdata_nxt[WPA_S_FAIL] = fail_r;
        rdata_nxt[WPA_S_LVL] = fail_r ? dir_lat_r : fail_direction_switch;
      end
      WPA_A_MODE: rdata_nxt[7:0] = mode_r;
      WPA_A_EVT: rdata_nxt[WPA_EVT_W-1:0] = evt_r;
      WPA_A_MASK: rdata_nxt[WPA_EVT_W-1:0] = mask_r;
      WPA_A_ALARM: rdata_nxt[7:0] = alarm_code;
      default: begin
        for (int k = 0; k < WPA_NVAR; k++) begin
          if (wb_adr_i == WPA_A_THR0 + 8'(k * 8)) begin
            rdata_nxt = 32'(thr_r[k].upper);
          end
          if (wb_adr_i == WPA_A_THR0 + 8'(k * 8 + 4)) begin
            rdata_nxt = 32'(thr_r[k].lower);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= '0;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      wb_dat_o <= rdata_nxt;
    end
  end

  // ==========================================================
  // Assertions.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_fail_silent: assert property (fail_r |=> !wb_ack_o ##1 !wb_ack_o)
    else $error("bus answered after failure");
  a_level_high: assert property (fail_r && dir_lat_r |=> loop_level >= WPA_LVL_HIGH)
    else $error("high failure level missing");
  a_level_low: assert property (fail_r && !dir_lat_r |=> loop_level <= WPA_LVL_LOW)
    else $error("low failure level missing");
  a_hw_inhibit: assert property (wr && write_inhibit_switch && wb_adr_i == WPA_A_MODE
                                 |=> $stable(mode_r))
    else $error("mode changed under write inhibit");
  a_sw_protect: assert property (wr && protect_r && !unl_active && wb_adr_i == WPA_A_THR0
                                 |=> $stable(thr_r[0]))
    else $error("threshold changed while protected");
  a_pw_store: assert property (npw_go && param_ok && npw_valid && !npw_spaces
                               |=> protect_r && pw_r == $past(npw_val))
    else $error("password not stored");
  a_unlock_open: assert property (unl_start |=> unl_active [*3])
    else $error("unlock window not open");
  a_protect_release: assert property (unl_stop |=> !protect_r && !unl_active)
    else $error("spaces did not clear protection");
  a_expire_lock: assert property (unl_expired && protect_r |-> !unl_active && !param_ok)
    else $error("writes still allowed after expiry");
  a_alarm_upper: assert property ((mode_r[1:0] == WPA_ALERT_UPPER) && pv_dp > thr_r[0].upper
                                  |=> alarm_code[0])
    else $error("upper alarm not raised");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  c_unlock: cover property (unl_start ##[1:20] wr && param_ok);
  c_reject: cover property (reject_ev);
  c_fail: cover property (fail_r && loop_level == WPA_LVL_LOW);
  c_irq: cover property (irq && evt_r[WPA_E_EXP]);

endmodule

// [wpa_unlock_timer.sv]
// Timed unlock window counter of the write-guard block.
// Assumes one clock; start and stop are single-cycle pulses from the register logic.
`timescale 1ns/1ps
module wpa_unlock_timer
  import wpa_pkg::*;
#(
  parameter longint CYCLES = WPA_UNLOCK_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic start,
  input wire logic stop,
  output logic active,
  output logic expired
);

  localparam int CW = $clog2(CYCLES + 1);

  // ==========================================================
  // Elaboration check.
  if (CYCLES < 1) begin : g_bad
    $error("unlock window must last at least one cycle");
  end

  logic [CW-1:0] cnt_r;

  // Counts the window down; a restart reloads the full length.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      active <= 1'b0;
      cnt_r <= '0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (stop) begin
        active <= 1'b0;
      end else if (start) begin
        active <= 1'b1;
        cnt_r <= CW'(CYCLES - 1);
      end else if (active) begin
        if (cnt_r == '0) begin
          active <= 1'b0;
          expired <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end

endmodule
